// File: dv/interconnect_traffic_regulation_tb_top.sv
// bench for the traffic-regulation block
// assumes itr_cfg.svh on the include path
`include "itr_cfg.svh"
module interconnect_traffic_regulation_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import itr_pkg::*;
  logic i_mclk, i_sys_rst, wreq, rq_free, rq_ready;
  avs_req_s avs;
  logic [31:0] rdata, rd;
  chan_req_s [1:0] req;
  cmpl_s [1:0] cmpl;
  logic [1:0] ready, tok_req, grant, fwdv, cntd;
  vn_t fvn, vn_seen;
  rq_req_s rq;
  logic [7:0] occ;
  int mismatches, check_count, w, lat;
  interconnect_traffic_regulation #(.RD_TRACKER(32), .QOS_UPPER(12), .QOS_LOWER(8)) u_dut (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_avs(avs), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_req(req), .o_ready(ready), .i_cmpl(cmpl),
    .o_tok_req(tok_req), .i_tok_grant(grant), .o_fwd_valid(fwdv), .o_fwd_vn(fvn),
    .i_rq(rq), .i_rq_free(rq_free), .o_rq_ready(rq_ready), .o_rq_occ(occ));
  itr_far_side u_far (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_fwd(fwdv),
    .i_tok_req(tok_req), .i_counted(cntd), .o_grant(grant), .o_cmpl(cmpl));
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // avalon access, held until the rising edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge i_mclk);
    avs <= '{read: !wr, write: wr, address: a, writedata: wd};
    do begin
      @(posedge i_mclk);
    end while (wreq !== 1'b0);
    // completing edge: data taken and request released here only
    rd = rdata;
    avs.read <= 1'b0;
    avs.write <= 1'b0;
  endtask
  // one channel request; w = cycles to take, lat = cycles take to send
  task automatic send(input int c, input logic [3:0] q, input logic dl, input int maxw);
    @(posedge i_mclk);
    req[c] <= '{valid: 1'b1, qos: q, dataless: dl};
    cntd[c] <= (q == 4'h0) && !dl;
    w = 0;
    lat = 0;
    do begin
      @(negedge i_mclk);
      w++;
    end while (ready[c] !== 1'b1 && w < maxw);
    @(posedge i_mclk);
    req[c].valid <= 1'b0;
    do begin
      @(negedge i_mclk);
      lat++;
    end while (fwdv[c] !== 1'b1 && lat < 20);
    vn_seen = fvn;
  endtask
  // queue entry; boost b applied while waiting
  task automatic rq_push(input logic [3:0] q, input logic [3:0] b, input logic exp);
    logic tk;
    tk = 1'b0;
    @(posedge i_mclk);
    rq <= '{valid: 1'b0, qos: q, read_arb_priority_boost: 4'h0};
    @(posedge i_mclk);
    rq.valid <= 1'b1;
    for (int n = 0; n < 8 && !tk; n++) begin
      @(negedge i_mclk);
      tk = (rq_ready === 1'b1);
      @(posedge i_mclk);
      rq.read_arb_priority_boost <= (n >= 2) ? b : 4'h0;
    end
    rq.valid <= 1'b0;
    chk("queue take", exp, tk);
  endtask
  task automatic t_regs();
    bus(1'b0, `ITR_CTRL_OFS, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    bus(1'b1, `ITR_STAT_OFS, 32'hFFFFFFFF);
    bus(1'b0, `ITR_STAT_OFS, 32'h0);
    chk("status ro", 32'h0, rd);
    bus(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h0, rd);
  endtask
  task automatic t_limit();
    send(0, 4'h0, 1'b0, 10);
    chk("disabled free", 1'b1, w <= 4);
    repeat (60) @(posedge i_mclk);
    bus(1'b1, `ITR_RDLIM_OFS, 32'h0000_0002);
    bus(1'b1, `ITR_CTRL_OFS, 32'h0000_0001);
    send(0, 4'h0, 1'b0, 10);
    send(0, 4'h0, 1'b0, 10);
    bus(1'b0, `ITR_STAT_OFS, 32'h0);
    chk("read count", 32'h2, rd & 32'hFF);
    send(0, 4'h3, 1'b0, 10);
    chk("qos pass", 1'b1, w <= 4);
    send(0, 4'h0, 1'b1, 10);
    chk("dataless pass", 1'b1, w <= 4);
    send(0, 4'h0, 1'b0, 100);
    chk("int stall", 1'b1, w > 8 && w < 100);
    repeat (60) @(posedge i_mclk);
    bus(1'b1, `ITR_RDLIM_OFS, 32'h0000_8001);
    send(0, 4'h0, 1'b0, 10);
    send(0, 4'h0, 1'b0, 10);
    chk("frac extra", 1'b1, w <= 4);
    send(0, 4'h0, 1'b0, 100);
    chk("frac stall", 1'b1, w > 8 && w < 100);
    repeat (60) @(posedge i_mclk);
  endtask
  task automatic t_token();
    for (int v = 0; v < 4; v++) begin
      bus(1'b1, `ITR_CTRL_OFS, {24'h0, (v % 2 == 1) ? 4'(1 << v) : 4'h0, 2'(v), 2'b00});
      send(1, 4'h1, 1'b0, 10);
      chk("net used", 32'(v), 32'(vn_seen));
      if (v % 2 == 1) chk("prealloc lat", 1'b1, lat == 1);
      else chk("token lat", 1'b1, lat >= 2 && lat < 20);
    end
  endtask
  task automatic t_queue();
    for (int i = 0; i < 28; i++) rq_push(4'h0, 4'h0, 1'b1);
    rq_push(4'h0, 4'h0, 1'b0);
    for (int i = 0; i < 3; i++) rq_push(4'h8, 4'h0, 1'b1);
    rq_push(4'h8, 4'h0, 1'b0);
    rq_push(4'hC, 4'h0, 1'b1);
    rq_push(4'hC, 4'h0, 1'b0);
    @(posedge i_mclk);
    rq_free <= 1'b1;
    @(posedge i_mclk);
    rq_free <= 1'b0;
    rq_push(4'h0, 4'hC, 1'b1);
    @(negedge i_mclk);
    chk("queue level", 32'h20, 32'(occ));
    repeat (32) begin
      @(posedge i_mclk);
      rq_free <= 1'b1;
      @(posedge i_mclk);
      rq_free <= 1'b0;
    end
    repeat (2) @(negedge i_mclk);
    chk("queue empty", 32'h0, 32'(occ));
  endtask
  task automatic print_verdict();
    $display("mismatches %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #400000;
    mismatches++;
    print_verdict();
  end
  initial begin
    i_sys_rst = 1'b1;
    avs = '0;
    req = '0;
    cntd = 2'b00;
    rq = '0;
    rq_free = 1'b0;
    repeat (2) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    repeat (5) @(posedge i_mclk);
    t_regs();
    t_limit();
    t_token();
    t_queue();
    print_verdict();
  end
endmodule // interconnect_traffic_regulation_tb_top

// File: dv/itr_far_side.sv
// far-side model: downstream token grants and completions
// assumes send pulses come from the block and counted flags from the bench
module itr_far_side #(
  parameter int LAT = 30, // completion delay
  parameter int GDLY = 2 // grant delay
) (
  input wire logic i_mclk, // clock
  input wire logic i_sys_rst, // reset
  input wire logic [1:0] i_fwd, // send pulses
  input wire logic [1:0] i_tok_req, // token wanted
  input wire logic [1:0] i_counted, // counted flag
  output logic [1:0] o_grant, // token given
  output itr_pkg::cmpl_s [1:0] o_cmpl // completions
);
  timeunit 1ns;
  timeprecision 1ps;
  import itr_pkg::*;
  logic [1:0][31:0] pend; // sends in flight
  logic [1:0][31:0] cflag; // their counted flags
  logic [1:0][3:0] tw; // token wait
  // delay lines and token wait counters
  always_ff @(posedge i_mclk) begin
    for (int c = 0; c < 2; c++) begin
      if (i_sys_rst) begin
        pend[c] <= '0;
        cflag[c] <= '0;
        tw[c] <= 4'h0;
      end else begin
        pend[c] <= {pend[c][30:0], i_fwd[c]};
        cflag[c] <= {cflag[c][30:0], i_counted[c]};
        tw[c] <= i_tok_req[c] ? tw[c] + {3'h0, tw[c] != 4'hF} : 4'h0;
      end
    end
  end
  // grant only when asked, completion later
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      o_grant[c] = i_tok_req[c] && (tw[c] >= 4'(GDLY));
      o_cmpl[c].done = pend[c][LAT-1];
      o_cmpl[c].counted = cflag[c][LAT-1];
    end
  end
endmodule // itr_far_side

// File: hw/interconnect_traffic_regulation.sv
// outstanding-transaction limiter, read queue admission and token gate
// assumes one clock, all request inputs on that clock, reset held 3 edges
`include "itr_cfg.svh"
module interconnect_traffic_regulation #(
  parameter int RD_TRACKER = 32,      // master read tracker entries
  parameter int QOS_UPPER = 12,       // qos at or above is high
  parameter int QOS_LOWER = 8         // qos at or above is medium
) (
  input wire logic i_mclk,                          // main clock
  input wire logic i_sys_rst,                       // reset, high
  input wire itr_pkg::avs_req_s i_avs,              // register request
  output logic [31:0] o_avs_readdata,               // register data
  output logic o_avs_waitrequest,                   // bus stall
  input wire itr_pkg::chan_req_s [1:0] i_req,       // 0 read, 1 write
  output logic [1:0] o_ready,                       // request taken
  input wire itr_pkg::cmpl_s [1:0] i_cmpl,          // completions
  output logic [1:0] o_tok_req,                     // token wanted
  input wire logic [1:0] i_tok_grant,               // token given
  output logic [1:0] o_fwd_valid,                   // send pulse
  output itr_pkg::vn_t o_fwd_vn,                    // network used
  input wire itr_pkg::rq_req_s i_rq,                // queue entry
  input wire logic i_rq_free,                       // entry retired
  output logic o_rq_ready,                          // entry taken
  output logic [7:0] o_rq_occ                       // queue level
);
  import itr_pkg::*;

  // ************************************************
  // build-time figures
  // ************************************************
  // small reservations
  localparam int HI_RES = (RD_TRACKER >= 5) ? 1 : 0;
  localparam int MED_RES = (RD_TRACKER >= 16) ? 3 : (RD_TRACKER >= 8) ? 1 : 0;
  localparam logic [7:0] CAP_HI = 8'(RD_TRACKER);
  localparam logic [7:0] CAP_MED = 8'(RD_TRACKER - HI_RES);
  localparam logic [7:0] CAP_LOW = 8'(RD_TRACKER - HI_RES - MED_RES);
  localparam logic [3:0] TH_HI = 4'(QOS_UPPER);
  localparam logic [3:0] TH_MED = 4'(QOS_LOWER);

  // refuse sizes and qos thresholds the logic cannot serve
  if (RD_TRACKER < 2 || RD_TRACKER > 128) begin : g_bad_size
    $error("tracker size must be 2 to 128");
  end
  if (QOS_UPPER < QOS_LOWER || QOS_UPPER > 15 || QOS_LOWER < 0) begin : g_bad_qos
    $error("qos thresholds out of order or range");
  end

  // ************************************************
  // state and decode
  // ************************************************
  state_s s;        // registered state
  state_s next_s;   // next state
  logic rst_q;      // synchronised reset
  logic [1:0] acc_req;    // handshake this cycle
  logic [1:0] counted;    // request falls under the limiter
  logic [1:0] dec;        // counted completion
  logic [1:0] en;         // limiter enabled
  logic [1:0][7:0] lim_int;
  logic [1:0][7:0] lim_frac;
  vn_t vn;                // slave network assignment
  logic [3:0] prealloc;   // networks holding a token
  logic [3:0] rq_prio;    // effective queue priority
  logic [7:0] rq_cap;     // admission cap of that priority
  logic rq_acc;           // queue entry taken
  logic rq_low;           // entry is low priority
  logic avs_go;           // bus access completes now

  assign rst_q = s.rst_sync;
  assign vn = s.ctrl[`ITR_CTRL_VN_LSB +: 2];
  assign prealloc = s.ctrl[`ITR_CTRL_PRE_LSB +: 4];
  assign rq_acc = i_rq.valid && s.rq_ready;
  assign avs_go = (i_avs.read || i_avs.write) && !s.waitreq;

  // per-channel decode
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      acc_req[c] = i_req[c].valid && s.ready[c];
      counted[c] = (i_req[c].qos == 4'h0) && !i_req[c].dataless;
      dec[c] = i_cmpl[c].done && i_cmpl[c].counted && (s.cnt[c] != 8'h00);
      en[c] = s.ctrl[`ITR_CTRL_EN_LSB + c];
      lim_int[c] = s.lim[c][7:0];
      lim_frac[c] = s.lim[c][`ITR_LIM_FRAC_LSB +: `ITR_FRAC_BITS];
    end
  end

  always_comb begin
    rq_prio = (i_rq.read_arb_priority_boost > i_rq.qos) ?
              i_rq.read_arb_priority_boost : i_rq.qos;
    if (rq_prio >= TH_HI) begin
      rq_cap = CAP_HI;
    end else if (rq_prio >= TH_MED) begin
      rq_cap = CAP_MED;
    end else begin
      rq_cap = CAP_LOW;
    end
    rq_low = (rq_prio < TH_MED);
  end

  // ************************************************
  // next state
  // ************************************************
  // one clock; a gated clock freezes everything
  always_comb begin
    logic signed [21:0] sum;
    logic permit;
    logic [7:0] occ_n;
    sum = '0;
    permit = 1'b0;
    occ_n = s.occ;
    next_s = s;
    next_s.rst_meta = i_sys_rst;
    next_s.rst_sync = s.rst_meta;
    if (s.rst_sync) begin
      // reset values
      next_s.ctrl = `ITR_CTRL_RST;
      next_s.lim = {2{`ITR_LIM_RST}};
      next_s.cnt = '0;
      next_s.acc = '0;
      next_s.st = '{CH_IDLE, CH_IDLE};
      next_s.ready = 2'b00;
      next_s.tok_req = 2'b00;
      next_s.fwd_valid = 2'b00;
      next_s.occ = 8'h00;
      next_s.rq_ready = 1'b0;
      next_s.waitreq = 1'b1;
      next_s.rdata = 32'h00000000;
    end else begin
      // register bus: one wait cycle, then complete
      next_s.waitreq = !((i_avs.read || i_avs.write) && s.waitreq);
      if (i_avs.read && s.waitreq) begin
        case (i_avs.address)
          `ITR_CTRL_OFS: next_s.rdata = {24'h000000, s.ctrl};
          `ITR_RDLIM_OFS: next_s.rdata = {16'h0000, s.lim[0]};
          `ITR_WRLIM_OFS: next_s.rdata = {16'h0000, s.lim[1]};
          `ITR_STAT_OFS: next_s.rdata = {8'h00, s.occ, s.cnt[1], s.cnt[0]};
          default: next_s.rdata = 32'h00000000; // unmapped reads zero
        endcase
      end
      if (avs_go && i_avs.write) begin
        case (i_avs.address)
          `ITR_CTRL_OFS: next_s.ctrl = i_avs.writedata[7:0];
          `ITR_RDLIM_OFS: next_s.lim[0] = i_avs.writedata[15:0];
          `ITR_WRLIM_OFS: next_s.lim[1] = i_avs.writedata[15:0];
          default: ; // status and unmapped ignore writes
        endcase
      end
      for (int c = 0; c < 2; c++) begin
        // count up on counted take, down on counted completion
        next_s.cnt[c] = s.cnt[c] + 8'(acc_req[c] && counted[c]) - 8'(dec[c]);
        // credit: limit minus level, capped at zero
        sum = $signed(s.acc[c]) + $signed({6'h00, lim_int[c], lim_frac[c]})
              - $signed({6'h00, s.cnt[c], 8'h00});
        if (sum > 0) begin
          next_s.acc[c] = '0;
        end else if (sum < $signed(`ITR_ACC_MIN)) begin
          next_s.acc[c] = `ITR_ACC_MIN;
        end else begin
          next_s.acc[c] = sum;
        end
        // token handshake per channel
        next_s.tok_req[c] = 1'b0;
        next_s.fwd_valid[c] = 1'b0;
        case (s.st[c])
          CH_IDLE: begin
            if (acc_req[c]) begin
              if (prealloc[vn]) begin
                next_s.st[c] = CH_SEND;
                next_s.fwd_valid[c] = 1'b1;
              end else begin
                next_s.st[c] = CH_TOKEN;
                next_s.tok_req[c] = 1'b1;
              end
            end
          end
          CH_TOKEN: begin
            if (i_tok_grant[c]) begin
              next_s.st[c] = CH_SEND;
              next_s.fwd_valid[c] = 1'b1;
            end else begin
              next_s.tok_req[c] = 1'b1;
            end
          end
          CH_SEND: begin
            // send is one cycle, never refused
            next_s.st[c] = CH_IDLE;
          end
          default: next_s.st[c] = CH_IDLE;
        endcase
        // permit from next level and credit
        if (next_s.cnt[c] < lim_int[c]) begin
          permit = 1'b1;
        end else if (lim_frac[c] != 8'h00 && next_s.cnt[c] == lim_int[c]) begin
          permit = !next_s.acc[c][21];
        end else begin
          permit = 1'b0;
        end
        next_s.ready[c] = (next_s.st[c] == CH_IDLE) && !acc_req[c] &&
                          (!en[c] || permit || (i_req[c].valid && !counted[c]));
      end
      occ_n = s.occ + 8'(rq_acc) - 8'(i_rq_free && s.occ != 8'h00);
      next_s.occ = occ_n;
      next_s.rq_ready = !rq_acc && (occ_n < rq_cap);
    end
  end

  // single state register
  always_ff @(posedge i_mclk) begin
    s <= next_s;
  end

  // ************************************************
  // outputs
  // ************************************************
  assign o_avs_readdata = s.rdata;
  assign o_avs_waitrequest = s.waitreq;
  assign o_ready = s.ready;
  assign o_tok_req = s.tok_req;
  assign o_fwd_valid = s.fwd_valid;
  assign o_fwd_vn = vn; // from the control register
  assign o_rq_ready = s.rq_ready;
  assign o_rq_occ = s.occ;

  // ************************************************
  // assertions, with three cover points among them
  // ************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (rst_q);

  a_frac0_cap: assert property (
    acc_req[0] && counted[0] && en[0] && lim_frac[0] == 8'h00 |-> s.cnt[0] < lim_int[0])
    else $error("read taken above zero-fraction limit");

  a_frac_cap: assert property (
    acc_req[0] && counted[0] && en[0] |-> s.cnt[0] <= lim_int[0])
    else $error("read taken above limit plus one");

  a_extra_credit: assert property (
    acc_req[0] && counted[0] && en[0] && s.cnt[0] == lim_int[0]
    |-> $past(!next_s.acc[0][21]))
    else $error("extra read taken without credit");

  a_qos_bypass: assert property (
    acc_req[0] && !counted[0] && !dec[0] |=> s.cnt[0] == $past(s.cnt[0]))
    else $error("nonzero qos read was counted");

  a_cmpl_retire: assert property (
    dec[0] && !acc_req[0] |=> s.cnt[0] == $past(s.cnt[0]) - 8'h01)
    else $error("read data did not retire");

  a_dataless_free: assert property (
    s.st[0] == CH_IDLE && i_req[0].valid && i_req[0].dataless && !acc_req[0]
    |=> s.ready[0])
    else $error("dataless read held back");

  a_stall_ready: assert property (
    en[0] && lim_frac[0] == 8'h00 && s.cnt[0] >= lim_int[0] && !dec[0] &&
    i_req[0].valid && counted[0] && $stable(s.lim[0]) |=> !s.ready[0])
    else $error("read not stalled at limit");

  a_tok_delay: assert property (
    acc_req[0] && !prealloc[vn] |=> s.tok_req[0] && !s.fwd_valid[0])
    else $error("send before token request");

  a_tok_send: assert property (
    s.st[1] == CH_TOKEN && i_tok_grant[1] |=> s.fwd_valid[1] ##1 !s.fwd_valid[1])
    else $error("granted write not sent once");

  a_rq_low_cap: assert property (
    rq_acc && $past(rq_low) && $stable(i_rq) |-> s.occ < CAP_LOW)
    else $error("low read took reserved slot");

  a_rq_bound: assert property (
    s.occ >= CAP_HI |-> !s.rq_ready)
    else $error("queue admits beyond tracker");

  a_avs_answer: assert property (
    (i_avs.read || i_avs.write) && s.waitreq |=> !s.waitreq ##1 s.waitreq)
    else $error("bus answer not one cycle");

  c_token_path: cover property (acc_req[0] ##1 s.tok_req[0] ##[1:4] s.fwd_valid[0]);
  c_extra_one: cover property (acc_req[0] && counted[0] && s.cnt[0] == lim_int[0]
                               && en[0]);
  c_queue_full: cover property (s.occ == CAP_HI);

  a_ready_drop: assert property (
    acc_req[0] |=> !s.ready[0])
    else $error("ready stayed high after take");

  a_tok_hold: assert property (
    s.tok_req[0] && !i_tok_grant[0] |=> s.tok_req[0] && !s.fwd_valid[0])
    else $error("token request dropped before grant");

  a_disabled_free: assert property (
    !en[0] && s.st[0] == CH_IDLE && !acc_req[0] |=> s.ready[0])
    else $error("disabled limiter stalled a read");

  a_occ_step: assert property (
    rq_acc && !i_rq_free |=> s.occ == $past(s.occ) + 8'h01)
    else $error("queue level not raised by take");

  // ************************************************
  // cover points
  // ************************************************
  c_boost_take: cover property (rq_acc && i_rq.read_arb_priority_boost > i_rq.qos);
  c_frac_stall: cover property (en[0] && lim_frac[0] != 8'h00 && i_req[0].valid
                                && !s.ready[0]);
endmodule // interconnect_traffic_regulation

// File: hw/itr_cfg.svh
// register offsets, field positions, reset values and timing counts
// assumes byte addressing on the register bus, one 32-bit word per register
`ifndef ITR_CFG_SVH
`define ITR_CFG_SVH
// byte offsets
`define ITR_CTRL_OFS 8'h00
`define ITR_RDLIM_OFS 8'h04
`define ITR_WRLIM_OFS 8'h08
`define ITR_STAT_OFS 8'h0C
// control field positions
`define ITR_CTRL_EN_LSB 0
`define ITR_CTRL_VN_LSB 2
`define ITR_CTRL_PRE_LSB 4
// limit field positions, fraction in 1/256 units
`define ITR_LIM_FRAC_LSB 8
`define ITR_FRAC_BITS 8
// status field positions
`define ITR_STAT_WR_LSB 8
`define ITR_STAT_OCC_LSB 16
// reset values
`define ITR_CTRL_RST 8'h00
`define ITR_LIM_RST 16'h0000
// credit accumulator floor
`define ITR_ACC_MIN 22'h380000
// least cycles from accept to send without a token
`define ITR_TOK_MIN_CYC 2
`endif

// File: hw/itr_pkg.sv
// types shared by the traffic-regulation block
// assumes itr_cfg.svh is on the include path
package itr_pkg;
  typedef logic [1:0] vn_t; // virtual network number
  // address request of one channel
  typedef struct packed {
    logic valid;
    logic [3:0] qos;
    logic dataless;
  } chan_req_s;
  // completion (last read beat or write response)
  typedef struct packed {
    logic done;
    logic counted;
  } cmpl_s;
  // read entering the master-side request queue
  typedef struct packed {
    logic valid;
    logic [3:0] qos;
    logic [3:0] read_arb_priority_boost;
  } rq_req_s;
  // avalon request side
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
  } avs_req_s;
  typedef enum logic [1:0] {CH_IDLE, CH_TOKEN, CH_SEND} chan_st_e;
  // whole state of the block
  typedef struct packed {
    logic rst_meta;
    logic rst_sync;
    logic [7:0] ctrl;
    logic [1:0][15:0] lim;
    logic [1:0][7:0] cnt;
    logic [1:0][21:0] acc;
    chan_st_e [1:0] st;
    logic [1:0] ready;
    logic [1:0] tok_req;
    logic [1:0] fwd_valid;
    logic [7:0] occ;
    logic rq_ready;
    logic waitreq;
    logic [31:0] rdata;
  } state_s;
endpackage
